/* File: rtl/mrs_cfg.svh */
// Constants for the serial slave telegram framer
`ifndef MRS_CFG_SVH
`define MRS_CFG_SVH
// Character time in bit times
`define MRS_CHAR_BITS 11
`define MRS_T15_BITS ((`MRS_CHAR_BITS * 3 + 1) / 2)
`define MRS_T35_BITS ((`MRS_CHAR_BITS * 7 + 1) / 2)
`define MRS_BCAST_ADDR 8'h00
`define MRS_ADDR_MAX 8'hF7
`define MRS_MIN_FRAME 8'h04
`define MRS_REQ_BYTES 6
`define MRS_RESP_BYTES 12
`define MRS_CRC_INIT 16'hFFFF
`define MRS_CRC_POLY 16'hA001
`define MRS_FC_NONE 8'h00
`define MRS_FC_RD_COILS 8'h01
`define MRS_FC_WR_COIL 8'h05
`define MRS_EXC_FLAG 8'h80
`define MRS_EXC_FUNC 8'h01
`define MRS_EXC_ADDR 8'h02
`define MRS_EXC_VALUE 8'h03
`define MRS_COIL_REF 16'h0010
`define MRS_COIL_STAT 16'h0020
`define MRS_COIL_STORE 16'h0040
`define MRS_COIL_COUNT 17'h00041
`define MRS_COIL_ON 16'hFF00
`define MRS_COIL_OFF 16'h0000
`define MRS_CTL_RST 16'h0000
`define MRS_REF_RST 16'h0000
`define MRS_STORE_RST 1'b0
`define MRS_FIFO_DEPTH 32
`endif

/* File: rtl/mrs_pkg.sv */
// Types of the serial slave telegram framer
package mrs_pkg;
    typedef enum logic [3:0] {
        RX_SYNC = 4'b0001,
        RX_IDLE = 4'b0010,
        RX_RECV = 4'b0100,
        RX_GAP  = 4'b1000
    } mrs_rx_t;
    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_BODY = 4'b0010,
        TX_CRCL = 4'b0100,
        TX_CRCH = 4'b1000
    } mrs_tx_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } mrs_byte_t;
    typedef struct packed {
        logic [1:0] presetRef;
        logic       dcBrake;
        logic       coastStop;
        logic       quickStop;
        logic       freezeFreq;
        logic       rampStop;
        logic       faultReset;
        logic       jog;
        logic       ramp2;
        logic       dataValid;
        logic       relay1;
        logic       relay2;
        logic       setupSel;
        logic       reverse;
    } mrs_cmd_t;
endpackage

/* File: rtl/mrs_framer.sv */
// Slave telegram framer with its response FIFO
//
// Operation
// - Accept a telegram only after 3.5 character times of bus silence.
// - A telegram ends after 3.5 character times of silence following it.
// - Reply bytes are queued back to back without gaps.
// - Silence over 1.5 character times closes the current frame.
// - Bytes arriving before 3.5 character times join the old frame; no reply.
// - Receiver always listens; first byte is the target address.
// - Truncated frames raise the error pulse.
// - Frame is address, function, data bytes, then 16-bit CRC.
// - Broadcast address 0 is acted on but never answered.
// - Own address 1 to 247; act only on own or broadcast address.
// - Every reply carries the own address first.
// - Function code zero is not a valid request.
// - A normal reply echoes the function code.
// - An exception reply sets the function top bit and adds a code.
// - CRC covers every byte regardless of parity.
// - Received CRC mismatch gives no reply.
// - CRC goes out low byte first, high byte last.
// - Coil addresses in frames are zero based.
// - Coils are single bits inside 16-bit words.
// - Coils 1-16 control word, 17-32 speed reference, written by master.
// - Coils 33-48 status word, 49-64 frequency or feedback, read only.
// - Coil 65 selects non-volatile parameter store; higher coils reserved.
// - Character is start, 8 data, parity and stop, or two stops.
// - Baud rate 2400 to 115200 set by bit divisor.
`timescale 1ns/100ps
`include "mrs_cfg.svh"

module mrs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `MRS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             ce,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    assign inReady  = count_r != (AW+1)'(DEPTH);
    assign outValid = count_r != '0;
    assign push     = ce && inValid && inReady;
    assign pop      = ce && outValid && outReady;
    assign outData  = mem_r[rdPtr_r];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= wrPtr_r + 1'b1;
            end
            if (pop) begin
                rdPtr_r <= rdPtr_r + 1'b1;
            end
            if (push && !pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop && !push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

module mrs_framer (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              ce,
    // Received characters
    input  wire mrs_pkg::mrs_byte_t rxIn,
    // Transmit characters
    output logic [7:0]             txData,
    output logic                   txValid,
    input  wire logic              txReady,
    // Configuration
    input  wire logic [15:0]       baudDiv,
    input  wire logic [7:0]        ownAddr,
    // Drive data
    input  wire logic [15:0]       statusWord,
    input  wire logic [15:0]       outWord,
    output mrs_pkg::mrs_cmd_t      cmd,
    output logic [15:0]            ctlWord,
    output logic [15:0]            speedRef,
    output logic                   storeNv,
    // Status
    output logic                   frameOk,
    output logic                   frameErr,
    output logic                   busy
);
    function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    localparam logic [5:0] T15 = 6'(`MRS_T15_BITS);
    localparam logic [5:0] T35 = 6'(`MRS_T35_BITS);

    mrs_pkg::mrs_rx_t rxState_r;
    mrs_pkg::mrs_rx_t rxState_nxt;
    mrs_pkg::mrs_tx_t txState_r;
    logic [15:0] baudCnt_r;
    logic [5:0]  idleBits_r;
    logic [7:0]  rxCount_r;
    logic [15:0] crc_r;
    logic [7:0]  req_r [`MRS_REQ_BYTES];
    logic        bad_r;
    logic [7:0]  resp_r [`MRS_RESP_BYTES];
    logic [7:0]  respNxt [`MRS_RESP_BYTES];
    logic [3:0]  respLen_r;
    logic [3:0]  lenNxt;
    logic [3:0]  txIdx_r;
    logic [15:0] txCrc_r;
    logic [7:0]  exc;
    logic        wrOk;
    logic        bitTick;
    logic        gap15;
    logic        gap35;
    logic        byteTake;
    logic        evalNow;
    logic        goodFrame;
    logic        forUs;
    logic        bcast;
    logic        fcValid;
    logic        loadResp;
    logic        doWrite;
    logic [15:0] startAddr;
    logic [15:0] qty;
    logic [16:0] endAddr;
    logic [71:0] coilImg;
    logic [71:0] coilBits;
    logic [7:0]  byteCnt;
    logic        fifoInValid;
    logic        fifoInReady;
    logic [7:0]  fifoInData;
    logic        txPush;
    logic        frameOk_r;
    logic        frameErr_r;

    // Bit timer restarts on each character so silence counts from its stop bit
    assign bitTick = ce && !rxIn.valid && baudCnt_r >= baudDiv - 16'h0001;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            baudCnt_r <= 16'h0000;
        end else if (ce) begin
            if (rxIn.valid || bitTick) begin
                baudCnt_r <= 16'h0000;
            end else begin
                baudCnt_r <= baudCnt_r + 16'h0001;
            end
        end
    end

    // Silence in bit times; one character is eleven bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idleBits_r <= 6'h00;
        end else if (ce) begin
            if (rxIn.valid) begin
                idleBits_r <= 6'h00;
            end else if (bitTick && idleBits_r != T35) begin
                idleBits_r <= idleBits_r + 6'h01;
            end
        end
    end

    assign gap15 = idleBits_r >= T15;
    assign gap35 = idleBits_r == T35;

    // Receiver never stops listening, even while replying
    always_comb begin
        rxState_nxt = rxState_r;
        case (rxState_r)
            mrs_pkg::RX_SYNC: begin
                if (!rxIn.valid && gap35) begin
                    rxState_nxt = mrs_pkg::RX_IDLE;
                end
            end
            mrs_pkg::RX_IDLE: begin
                if (rxIn.valid) begin
                    rxState_nxt = mrs_pkg::RX_RECV;
                end
            end
            mrs_pkg::RX_RECV: begin
                if (!rxIn.valid && gap15) begin
                    rxState_nxt = mrs_pkg::RX_GAP;
                end
            end
            mrs_pkg::RX_GAP: begin
                if (rxIn.valid) begin
                    rxState_nxt = mrs_pkg::RX_RECV;
                end else if (gap35) begin
                    rxState_nxt = mrs_pkg::RX_IDLE;
                end
            end
            default: rxState_nxt = mrs_pkg::RX_SYNC;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxState_r <= mrs_pkg::RX_SYNC;
        end else if (ce) begin
            rxState_r <= rxState_nxt;
        end
    end

    assign byteTake = ce && rxIn.valid && rxState_r != mrs_pkg::RX_SYNC;
    assign evalNow  = ce && rxState_r == mrs_pkg::RX_GAP && !rxIn.valid && gap35;

    // Frame capture: first byte restarts count and CRC
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxCount_r <= 8'h00;
            crc_r     <= `MRS_CRC_INIT;
            bad_r     <= 1'b0;
            for (int i = 0; i < `MRS_REQ_BYTES; i++) begin
                req_r[i] <= 8'h00;
            end
        end else if (byteTake) begin
            if (rxState_r == mrs_pkg::RX_IDLE) begin
                rxCount_r <= 8'h01;
                crc_r     <= crcByte(`MRS_CRC_INIT, rxIn.data);
                bad_r     <= 1'b0;
                req_r[0]  <= rxIn.data;
            end else begin
                if (rxCount_r != 8'hFF) begin
                    rxCount_r <= rxCount_r + 8'h01;
                end
                crc_r <= crcByte(crc_r, rxIn.data);
                if (rxState_r == mrs_pkg::RX_GAP) begin
                    bad_r <= 1'b1;
                end
                if (rxCount_r < 8'(`MRS_REQ_BYTES)) begin
                    req_r[3'(rxCount_r)] <= rxIn.data;
                end
            end
        end
    end

    // Residue of zero over data plus CRC means a clean frame
    assign goodFrame = !bad_r && rxCount_r >= `MRS_MIN_FRAME && crc_r == 16'h0000;
    assign bcast     = req_r[0] == `MRS_BCAST_ADDR;
    assign forUs     = req_r[0] == ownAddr && ownAddr != `MRS_BCAST_ADDR
                       && ownAddr <= `MRS_ADDR_MAX;
    assign fcValid   = req_r[1] != `MRS_FC_NONE;
    assign startAddr = {req_r[2], req_r[3]};
    assign qty       = {req_r[4], req_r[5]};
    assign endAddr   = {1'b0, startAddr} + {1'b0, qty};
    // Coil image, bit 0 is coil 1
    assign coilImg   = {7'h00, storeNv, outWord, statusWord, speedRef, ctlWord};
    assign coilBits  = (coilImg >> startAddr[6:0])
                       & ((72'h1 << qty[6:0]) - 72'h1);
    assign byteCnt   = 8'((qty + 16'h0007) >> 3);

    always_comb begin
        for (int i = 0; i < `MRS_RESP_BYTES; i++) begin
            respNxt[i] = 8'h00;
        end
        lenNxt     = 4'h0;
        exc        = 8'h00;
        wrOk       = 1'b0;
        respNxt[0] = ownAddr;
        respNxt[1] = req_r[1];
        case (req_r[1])
            `MRS_FC_RD_COILS: begin
                if (qty == 16'h0000 || qty > 16'(`MRS_COIL_COUNT)) begin
                    exc = `MRS_EXC_VALUE;
                end else if (endAddr > `MRS_COIL_COUNT) begin
                    exc = `MRS_EXC_ADDR;
                end else begin
                    respNxt[2] = byteCnt;
                    for (int k = 0; k < 9; k++) begin
                        respNxt[3+k] = coilBits[8*k +: 8];
                    end
                    lenNxt = 4'(byteCnt + 8'h03);
                end
            end
            `MRS_FC_WR_COIL: begin
                if (qty != `MRS_COIL_ON && qty != `MRS_COIL_OFF) begin
                    exc = `MRS_EXC_VALUE;
                end else if (startAddr >= `MRS_COIL_STAT
                             && startAddr != `MRS_COIL_STORE) begin
                    exc = `MRS_EXC_ADDR;
                end else begin
                    wrOk = 1'b1;
                    for (int i = 2; i < `MRS_REQ_BYTES; i++) begin
                        respNxt[i] = req_r[i];
                    end
                    lenNxt = 4'(`MRS_REQ_BYTES);
                end
            end
            default: exc = `MRS_EXC_FUNC;
        endcase
        if (exc != 8'h00) begin
            respNxt[1] = req_r[1] | `MRS_EXC_FLAG;
            respNxt[2] = exc;
            lenNxt     = 4'h3;
        end
    end

    // A request ending while a reply is still being pushed into the FIFO gets no reply; its write still applies
    assign loadResp = evalNow && goodFrame && forUs && fcValid
                      && txState_r == mrs_pkg::TX_IDLE;
    assign doWrite  = evalNow && goodFrame && (forUs || bcast) && fcValid && wrOk;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            respLen_r <= 4'h0;
            for (int i = 0; i < `MRS_RESP_BYTES; i++) begin
                resp_r[i] <= 8'h00;
            end
        end else if (loadResp) begin
            respLen_r <= lenNxt;
            for (int i = 0; i < `MRS_RESP_BYTES; i++) begin
                resp_r[i] <= respNxt[i];
            end
        end
    end

    // Coil writes land in the word that holds them
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctlWord  <= `MRS_CTL_RST;
            speedRef <= `MRS_REF_RST;
            storeNv  <= `MRS_STORE_RST;
        end else if (doWrite) begin
            if (startAddr < `MRS_COIL_REF) begin
                ctlWord[startAddr[3:0]] <= qty == `MRS_COIL_ON;
            end else if (startAddr < `MRS_COIL_STAT) begin
                speedRef[startAddr[3:0]] <= qty == `MRS_COIL_ON;
            end else begin
                storeNv <= qty == `MRS_COIL_ON;
            end
        end
    end

    // Zero on stop bits asserts the stop, the reset value is therefore safe
    assign cmd.presetRef  = ctlWord[1:0];
    assign cmd.dcBrake    = ~ctlWord[2];
    assign cmd.coastStop  = ~ctlWord[3];
    assign cmd.quickStop  = ~ctlWord[4];
    assign cmd.freezeFreq = ~ctlWord[5];
    assign cmd.rampStop   = ~ctlWord[6];
    assign cmd.faultReset = ctlWord[7];
    assign cmd.jog        = ctlWord[8];
    assign cmd.ramp2      = ctlWord[9];
    assign cmd.dataValid  = ctlWord[10];
    assign cmd.relay1     = ctlWord[11];
    assign cmd.relay2     = ctlWord[12];
    assign cmd.setupSel   = ctlWord[13];
    assign cmd.reverse    = ctlWord[15];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frameOk_r  <= 1'b0;
            frameErr_r <= 1'b0;
        end else if (ce) begin
            frameOk_r  <= evalNow && goodFrame && (forUs || bcast) && fcValid;
            frameErr_r <= evalNow && (!goodFrame || ((forUs || bcast) && !fcValid));
        end
    end

    assign frameOk  = frameOk_r;
    assign frameErr = frameErr_r;

    // Reply bytes stream without pause whenever the FIFO accepts
    assign fifoInValid = txState_r != mrs_pkg::TX_IDLE;
    assign txPush      = ce && fifoInValid && fifoInReady;
    always_comb begin
        case (txState_r)
            mrs_pkg::TX_CRCL: fifoInData = txCrc_r[7:0];
            mrs_pkg::TX_CRCH: fifoInData = txCrc_r[15:8];
            default:          fifoInData = resp_r[txIdx_r];
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txState_r <= mrs_pkg::TX_IDLE;
            txIdx_r   <= 4'h0;
            txCrc_r   <= `MRS_CRC_INIT;
        end else if (ce) begin
            case (txState_r)
                mrs_pkg::TX_IDLE: begin
                    if (loadResp) begin
                        txState_r <= mrs_pkg::TX_BODY;
                        txIdx_r   <= 4'h0;
                        txCrc_r   <= `MRS_CRC_INIT;
                    end
                end
                mrs_pkg::TX_BODY: begin
                    if (txPush) begin
                        txCrc_r <= crcByte(txCrc_r, fifoInData);
                        txIdx_r <= txIdx_r + 4'h1;
                        if (txIdx_r == respLen_r - 4'h1) begin
                            txState_r <= mrs_pkg::TX_CRCL;
                        end
                    end
                end
                mrs_pkg::TX_CRCL: begin
                    if (txPush) begin
                        txState_r <= mrs_pkg::TX_CRCH;
                    end
                end
                mrs_pkg::TX_CRCH: begin
                    if (txPush) begin
                        txState_r <= mrs_pkg::TX_IDLE;
                    end
                end
                default: txState_r <= mrs_pkg::TX_IDLE;
            endcase
        end
    end

    mrs_fifo #(
        .WIDTH (8),
        .DEPTH (`MRS_FIFO_DEPTH)
    ) u_txFifo (
        .clk      (clk),
        .reset_n  (reset_n),
        .ce       (ce),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .inData   (fifoInData),
        .outValid (txValid),
        .outReady (txReady),
        .outData  (txData)
    );

    assign busy = txState_r != mrs_pkg::TX_IDLE || txValid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_crcLow;
        txPush && txState_r == mrs_pkg::TX_CRCL;
    endsequence
    sequence s_crcHigh;
        txState_r == mrs_pkg::TX_CRCH && fifoInData == txCrc_r[15:8];
    endsequence

    a_sync_silence: assert property (
        (ce && rxState_r == mrs_pkg::RX_SYNC && rxState_nxt == mrs_pkg::RX_IDLE)
        |-> idleBits_r == T35)
        else $error("left sync before full silence");
    a_gap_close: assert property (
        (ce && rxState_r == mrs_pkg::RX_RECV && !rxIn.valid && gap15)
        |=> rxState_r == mrs_pkg::RX_GAP)
        else $error("frame not closed after short silence");
    a_join_bad: assert property (
        (byteTake && rxState_r == mrs_pkg::RX_GAP) |=> bad_r ##1 !frameOk_r)
        else $error("joined frame not marked bad");
    a_trunc_error: assert property (
        (evalNow && rxCount_r < `MRS_MIN_FRAME) |=> frameErr_r && !frameOk_r)
        else $error("short frame without error");
    a_bcast_silent: assert property (
        (evalNow && bcast && txState_r == mrs_pkg::TX_IDLE) |=> txState_r == mrs_pkg::TX_IDLE)
        else $error("reply to broadcast");
    a_crc_silent: assert property (
        (evalNow && crc_r != 16'h0000) |-> !loadResp ##1 frameErr_r)
        else $error("reply despite bad crc");
    a_reply_addr: assert property (
        (txPush && txState_r == mrs_pkg::TX_BODY && txIdx_r == 4'h0)
        |-> fifoInData == ownAddr)
        else $error("reply address wrong");
    a_exc_reply: assert property (
        (loadResp && exc != 8'h00) |=> resp_r[1][7] && resp_r[2] == $past(exc)
        && respLen_r == 4'h3)
        else $error("exception reply malformed");
    a_crc_order: assert property (
        s_crcLow |=> s_crcHigh)
        else $error("crc high byte not after low byte");
    a_fc_zero: assert property (
        (evalNow && goodFrame && forUs && !fcValid) |-> !loadResp ##1 frameErr_r)
        else $error("function zero accepted");
endmodule

/* File: verification/mrs_master_model.sv */
// Bus master model: sends request characters and drains replies
`timescale 1ns/100ps
module mrs_master_model (
    // Clock
    input  wire logic          clk,
    // Request characters
    output mrs_pkg::mrs_byte_t rxOut,
    // Reply characters
    output logic               txReady
);
    logic [3:0] stallCnt = 4'h0;
    initial rxOut = '0;
    initial txReady = 1'b0;
    // Stall one cycle in four so the reply queue sees back pressure
    always @(posedge clk) begin
        stallCnt <= stallCnt + 4'h1;
        txReady  <= (stallCnt[1:0] != 2'h3);
    end
    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] d);
        c = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        return c;
    endfunction
    task automatic sendChar(input logic [7:0] b);
        @(posedge clk);
        rxOut <= {1'b1, b};
        @(posedge clk);
        rxOut.valid <= 1'b0;
    endtask
    // Characters go out back to back, CRC low byte then high byte last
    task automatic sendFrame(input logic [7:0] b [6], input logic badCrc, input int gap = 160);
        logic [15:0] crc;
        crc = 16'hFFFF;
        for (int i = 0; i < 6; i++) begin
            sendChar(b[i]);
            crc = crcStep(crc, b[i]);
        end
        if (badCrc) begin
            crc = crc ^ 16'h0001;
        end
        sendChar(crc[7:0]);
        sendChar(crc[15:8]);
        repeat (gap) @(posedge clk);
    endtask
endmodule

/* File: verification/mrs_framer_bench.sv */
// Self-checking bench of the slave telegram framer
`timescale 1ns/100ps
module mrs_framer_bench;
    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    logic               ce = 1'b1;
    logic        [15:0] baudDiv = 16'h0002;
    logic        [7:0]  ownAddr = 8'h05;
    logic        [15:0] statusWord = 16'h0000;
    logic        [15:0] outWord = 16'h0000;
    mrs_pkg::mrs_byte_t rxIn;
    mrs_pkg::mrs_cmd_t  cmd;
    logic        [7:0]  txData;
    logic               txValid, txReady, frameOk, frameErr, busy, storeNv;
    logic        [15:0] ctlWord, speedRef;
    logic        [7:0]  expQ [$];
    logic        [7:0]  req [6];
    logic        [31:0] rnd;
    int                 errCount = 0, okCount = 0;
    int                 bad_count = 0, check_count = 0, cycles = 0, seed = 1167;
    initial forever #5 clk = ~clk;
    mrs_framer dut (.clk(clk), .reset_n(reset_n), .ce(ce), .rxIn(rxIn), .txData(txData),
        .txValid(txValid), .txReady(txReady), .baudDiv(baudDiv), .ownAddr(ownAddr),
        .statusWord(statusWord), .outWord(outWord), .cmd(cmd), .ctlWord(ctlWord),
        .speedRef(speedRef), .storeNv(storeNv), .frameOk(frameOk), .frameErr(frameErr),
        .busy(busy));
    mrs_master_model master (.clk(clk), .rxOut(rxIn), .txReady(txReady));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Queue a reply with its CRC, low byte first
    task automatic expectReply(input logic [7:0] r [6], input int n);
        logic [15:0] crc;
        crc = 16'hFFFF;
        for (int i = 0; i < n; i++) begin
            expQ.push_back(r[i]);
            crc = master.crcStep(crc, r[i]);
        end
        expQ.push_back(crc[7:0]);
        expQ.push_back(crc[15:8]);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Reply monitor: every popped byte must match the oldest note
    always @(posedge clk) begin
        errCount <= errCount + int'(frameErr);
        okCount  <= okCount + int'(frameOk);
        cycles  <= cycles + 1;
        if (reset_n && ce && txValid && txReady) begin
            if (expQ.size() == 0) begin
                check("unexpected reply byte", 16'h0000, 16'hFFFF);
            end else begin
                check("reply byte", {8'h00, expQ.pop_front()}, {8'h00, txData});
            end
        end
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        rnd = $random(seed);
        statusWord <= rnd[15:0];
        outWord <= rnd[31:16];
        repeat (100) @(posedge clk);
        check("stop flag at reset", 16'h0001, {15'h0, cmd.dcBrake});
        req = '{8'h05, 8'h05, 8'h00, 8'h00, 8'hFF, 8'h00};
        expectReply(req, 6);
        master.sendFrame(req, 1'b0);
        check("control word", 16'h0001, ctlWord);
        check("preset select", 16'h0001, {14'h0, cmd.presetRef});
        req[3] = 8'h10;
        expectReply(req, 6);
        master.sendFrame(req, 1'b0);
        check("speed reference", 16'h0001, speedRef);
        req = '{8'h05, 8'h01, 8'h00, 8'h20, 8'h00, 8'h10};
        expectReply('{8'h05, 8'h01, 8'h02, statusWord[7:0], statusWord[15:8], 8'h00}, 5);
        master.sendFrame(req, 1'b0);
        req[3] = 8'h30;
        expectReply('{8'h05, 8'h01, 8'h02, outWord[7:0], outWord[15:8], 8'h00}, 5);
        master.sendFrame(req, 1'b0);
        req = '{8'h05, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
        expectReply('{8'h05, 8'h83, 8'h01, 8'h00, 8'h00, 8'h00}, 3);
        master.sendFrame(req, 1'b0);
        req = '{8'h00, 8'h05, 8'h00, 8'h40, 8'hFF, 8'h00};
        master.sendFrame(req, 1'b0);
        check("store select", 16'h0001, {15'h0, storeNv});
        req = '{8'h05, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
        master.sendFrame(req, 1'b1);
        master.sendFrame(req, 1'b0, 50);
        master.sendFrame(req, 1'b0);
        req[1] = 8'h00;
        master.sendFrame(req, 1'b0);
        req = '{8'h07, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
        master.sendFrame(req, 1'b0);
        repeat (3) master.sendChar(8'h05);
        repeat (160) @(posedge clk);
        check("error pulses", 16'h0004, 16'(errCount));
        check("good pulses", 16'h0006, 16'(okCount));
        check("control word kept", 16'h0001, ctlWord);
        check("busy at end", 16'h0000, {15'h0, busy});
        check("notes left", 16'h0000, 16'(expQ.size()));
        summarize();
    end
endmodule
